// ---- common/pss_pkg.sv ----
package pss_pkg;

  // Register byte offsets
  localparam logic [7:0] ADR_RECALL = 8'h00;
  localparam logic [7:0] ADR_STORE  = 8'h04;
  localparam logic [7:0] ADR_MODE   = 8'h08;
  localparam logic [7:0] ADR_STEP   = 8'h0c;
  localparam logic [7:0] ADR_FIRST  = 8'h10;
  localparam logic [7:0] ADR_LAST   = 8'h14;
  localparam logic [7:0] ADR_LOOPS  = 8'h18;
  localparam logic [7:0] ADR_SET_V  = 8'h1c;
  localparam logic [7:0] ADR_SET_I  = 8'h20;
  localparam logic [7:0] ADR_SET_P  = 8'h24;
  localparam logic [7:0] ADR_STAT   = 8'h28;
  localparam logic [7:0] ADR_MASK   = 8'h2c;

  // Field widths and positions
  localparam int STEP_W  = 7;
  localparam int LOOP_W  = 10;
  localparam int SET_W   = 16;
  localparam int SLOT_W  = 2;
  localparam int REP_LSB = 16;
  localparam int EV_W    = 2;
  localparam int EV_ERR  = 0;
  localparam int EV_DONE = 1;

  // Limits and reset values
  localparam logic [STEP_W-1:0] STEP_MAX  = 7'h63;
  localparam logic [LOOP_W-1:0] LOOP_MAX  = 10'h3e7;
  localparam logic [SLOT_W-1:0] SLOT_MAX  = 2'h3;
  localparam logic [LOOP_W-1:0] REP_FIRST = 10'h001;
  localparam logic [SET_W-1:0]  SET_RST   = 16'h0000;
  localparam logic [1:0]        MODE_MAX  = 2'h2;

  typedef enum logic [1:0] {
    PSS_STOP,
    PSS_WAIT,
    PSS_RUN
  } pss_mode_type;

endpackage

// ---- hw/pss_preset_mem.sv ----
`timescale 1ns/10ps
module pss_preset_mem #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 3
) (
  input  wire logic                     clk,
  input  wire logic                     ce,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic                     re,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [WIDTH-1:0]         rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Slot storage, read data registered
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
    if (ce && re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ---- hw/pss_seq_engine.sv ----
`timescale 1ns/10ps
module pss_seq_engine (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic                          mode_we,
  input  wire pss_pkg::pss_mode_type         mode_val,
  input  wire logic                          jump_we,
  input  wire logic [pss_pkg::STEP_W-1:0]    jump_val,
  input  wire logic [pss_pkg::STEP_W-1:0]    first_step,
  input  wire logic [pss_pkg::STEP_W-1:0]    last_step,
  input  wire logic [pss_pkg::LOOP_W-1:0]    loop_count,
  input  wire logic                          step_tick,
  output pss_pkg::pss_mode_type              mode_q,
  output logic      [pss_pkg::STEP_W-1:0]    step_q,
  output logic      [pss_pkg::LOOP_W-1:0]    rep_q,
  output logic                               done_q
);
  import pss_pkg::*;

  pss_mode_type      mode_d;
  logic [STEP_W-1:0] step_d;
  logic [LOOP_W-1:0] rep_d;
  logic              done_d;
  logic              pass_end;
  logic              last_pass;

  assign pass_end  = step_q == last_step;
  assign last_pass = (loop_count != '0) && (rep_q >= loop_count);

  always_comb begin
    mode_d = mode_q;
    step_d = step_q;
    rep_d  = rep_q;
    done_d = 1'b0;
    if (mode_we) begin
      mode_d = mode_val;
      if (mode_q == PSS_STOP && mode_val != PSS_STOP) begin
        step_d = first_step;
        rep_d  = REP_FIRST;
      end
    end else if (jump_we) begin
      step_d = jump_val;
    end else if (mode_q == PSS_RUN && step_tick) begin
      if (pass_end) begin
        if (last_pass) begin
          mode_d = PSS_STOP;
          done_d = 1'b1;
        end else begin
          step_d = first_step;
          if (rep_q != LOOP_MAX) begin
            rep_d = rep_q + 10'h001;
          end
        end
      end else begin
        step_d = (step_q == STEP_MAX) ? '0 : step_q + 7'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= PSS_STOP;
      step_q <= '0;
      rep_q  <= '0;
      done_q <= 1'b0;
    end else if (ce) begin
      mode_q <= mode_d;
      step_q <= step_d;
      rep_q  <= rep_d;
      done_q <= done_d;
    end
  end

  jump_move_a: assert property (@(posedge clk) disable iff (rst || !ce)
    jump_we && !mode_we |=> step_q == $past(jump_val))
    else $error("jump did not move the step");

  mode_start_a: assert property (@(posedge clk) disable iff (rst || !ce)
    mode_we && mode_q == PSS_STOP && mode_val == PSS_RUN
    |=> mode_q == PSS_RUN && step_q == $past(first_step) && rep_q == REP_FIRST)
    else $error("start did not load first step");

  endless_a: assert property (@(posedge clk) disable iff (rst || !ce)
    !mode_we && mode_q == PSS_RUN && step_tick && pass_end && loop_count == '0
    |=> mode_q == PSS_RUN && !done_q)
    else $error("endless sequence stopped");

  pass_done_a: assert property (@(posedge clk) disable iff (rst || !ce)
    !mode_we && !jump_we && mode_q == PSS_RUN && step_tick && pass_end && last_pass
    |=> mode_q == PSS_STOP && done_q ##1 !done_q)
    else $error("final pass did not stop");

endmodule

// ---- hw/pss_top.sv ----
`timescale 1ns/10ps
// What this block does
// - Recall value 0 cancels preset, 1 to 3 loads that stored slot.
// - Recall query returns selected slot number.
// - Recall, store and step jump are rejected with error while running.
// - Store copies voltage, current, power setpoints into slot 1 to 3; no query.
// - Mode codes: 0 stopped, 1 waiting, 2 running.
// - Mode query returns the present mode code.
// - Step jump takes 0 to 99, acts only while waiting.
// - Step query returns current step and current repetition count.
// - First step is writable 0 to 99, readable, starts each pass.
// - Last step is writable 0 to 99, readable, ends each pass.
// - Loop count is writable 0 to 999, readable, sets number of passes.
// - Loop count zero repeats the sequence until stopped.
module pss_top (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic      [31:0]                  hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic                              irq,
  input  wire logic                         step_tick,
  output logic      [pss_pkg::SET_W-1:0]    set_volt,
  output logic      [pss_pkg::SET_W-1:0]    set_curr,
  output logic      [pss_pkg::SET_W-1:0]    set_pwr,
  output logic      [pss_pkg::SLOT_W-1:0]   preset_sel,
  output pss_pkg::pss_mode_type             seq_mode,
  output logic      [pss_pkg::STEP_W-1:0]   cur_step,
  output logic      [pss_pkg::LOOP_W-1:0]   cur_rep
);
  import pss_pkg::*;

  function automatic logic over(input logic [31:0] v, input logic [31:0] m);
    return v > m;
  endfunction

  logic                a_valid_q;
  logic                a_valid_d;
  logic                a_wr_q;
  logic                a_wr_d;
  logic [7:0]          a_addr_q;
  logic [7:0]          a_addr_d;
  logic [31:0]         hrdata_d;
  logic [SLOT_W-1:0]   sel_d;
  logic [SET_W-1:0]    volt_d;
  logic [SET_W-1:0]    curr_d;
  logic [SET_W-1:0]    pwr_d;
  logic [STEP_W-1:0]   first_q;
  logic [STEP_W-1:0]   first_d;
  logic [STEP_W-1:0]   last_q;
  logic [STEP_W-1:0]   last_d;
  logic [LOOP_W-1:0]   loops_q;
  logic [LOOP_W-1:0]   loops_d;
  logic [EV_W-1:0]     stat_q;
  logic [EV_W-1:0]     stat_d;
  logic [EV_W-1:0]     mask_q;
  logic [EV_W-1:0]     mask_d;
  logic [EV_W-1:0]     ev;
  logic [EV_W-1:0]     clr;
  logic                pend_q;
  logic                pend_d;
  logic                err;
  logic                wr;
  logic                rd_req;
  logic                running;
  logic                mem_we;
  logic                mem_re;
  logic [SLOT_W-1:0]   mem_slot;
  logic [3*SET_W-1:0]  mem_rdata;
  logic                mode_we;
  logic                jump_we;
  logic                seq_done;

  assign wr      = a_valid_q && a_wr_q;
  assign rd_req  = hready && hsel && htrans[1] && !hwrite;
  assign running = seq_mode == PSS_RUN;

  // Address phase capture
  always_comb begin
    a_valid_d = a_valid_q;
    a_wr_d    = a_wr_q;
    a_addr_d  = a_addr_q;
    if (hready) begin
      a_valid_d = hsel && htrans[1];
      a_wr_d    = hwrite;
      a_addr_d  = haddr[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_valid_q <= 1'b0;
      a_wr_q    <= 1'b0;
      a_addr_q  <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      a_valid_q <= a_valid_d;
      a_wr_q    <= a_wr_d;
      a_addr_q  <= a_addr_d;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Command execution in the write data phase
  always_comb begin
    sel_d    = preset_sel;
    volt_d   = set_volt;
    curr_d   = set_curr;
    pwr_d    = set_pwr;
    first_d  = first_q;
    last_d   = last_q;
    loops_d  = loops_q;
    mask_d   = mask_q;
    clr      = '0;
    err      = 1'b0;
    mem_we   = 1'b0;
    mem_re   = 1'b0;
    mode_we  = 1'b0;
    jump_we  = 1'b0;
    pend_d   = 1'b0;
    mem_slot = hwdata[SLOT_W-1:0] - 2'h1;
    if (pend_q) begin
      {pwr_d, curr_d, volt_d} = mem_rdata;
    end
    if (wr) begin
      case (a_addr_q)
        ADR_RECALL: begin
          if (running || over(hwdata, 32'(SLOT_MAX))) begin
            err = 1'b1;
          end else begin
            sel_d = hwdata[SLOT_W-1:0];
            if (hwdata[SLOT_W-1:0] != '0) begin
              mem_re = 1'b1;
              pend_d = 1'b1;
            end
          end
        end
        ADR_STORE: begin
          if (running || over(hwdata, 32'(SLOT_MAX)) || hwdata[SLOT_W-1:0] == '0) begin
            err = 1'b1;
          end else begin
            mem_we = 1'b1;
          end
        end
        ADR_MODE: begin
          if (over(hwdata, 32'(MODE_MAX))) begin
            err = 1'b1;
          end else begin
            mode_we = 1'b1;
          end
        end
        ADR_STEP: begin
          if (seq_mode != PSS_WAIT || over(hwdata, 32'(STEP_MAX))) begin
            err = 1'b1;
          end else begin
            jump_we = 1'b1;
          end
        end
        ADR_FIRST: begin
          if (over(hwdata, 32'(STEP_MAX))) begin
            err = 1'b1;
          end else begin
            first_d = hwdata[STEP_W-1:0];
          end
        end
        ADR_LAST: begin
          if (over(hwdata, 32'(STEP_MAX))) begin
            err = 1'b1;
          end else begin
            last_d = hwdata[STEP_W-1:0];
          end
        end
        ADR_LOOPS: begin
          if (over(hwdata, 32'(LOOP_MAX))) begin
            err = 1'b1;
          end else begin
            loops_d = hwdata[LOOP_W-1:0];
          end
        end
        ADR_SET_V: volt_d = hwdata[SET_W-1:0];
        ADR_SET_I: curr_d = hwdata[SET_W-1:0];
        ADR_SET_P: pwr_d = hwdata[SET_W-1:0];
        ADR_STAT: clr = hwdata[EV_W-1:0];
        ADR_MASK: mask_d = hwdata[EV_W-1:0];
        default: err = 1'b0;
      endcase
    end
    // Event set wins over clear
    ev          = '0;
    ev[EV_ERR]  = err;
    ev[EV_DONE] = seq_done;
    stat_d      = (stat_q & ~clr) | ev;
  end

  // Read data for the next data phase
  always_comb begin
    hrdata_d = 32'h0000_0000;
    if (rd_req) begin
      case (haddr[7:0])
        ADR_RECALL: hrdata_d[SLOT_W-1:0] = sel_d;
        ADR_MODE: hrdata_d[1:0] = seq_mode;
        ADR_STEP: begin
          hrdata_d[STEP_W-1:0]               = cur_step;
          hrdata_d[REP_LSB+LOOP_W-1:REP_LSB] = cur_rep;
        end
        ADR_FIRST: hrdata_d[STEP_W-1:0] = first_d;
        ADR_LAST: hrdata_d[STEP_W-1:0] = last_d;
        ADR_LOOPS: hrdata_d[LOOP_W-1:0] = loops_d;
        ADR_SET_V: hrdata_d[SET_W-1:0] = volt_d;
        ADR_SET_I: hrdata_d[SET_W-1:0] = curr_d;
        ADR_SET_P: hrdata_d[SET_W-1:0] = pwr_d;
        ADR_STAT: hrdata_d[EV_W-1:0] = stat_d;
        ADR_MASK: hrdata_d[EV_W-1:0] = mask_d;
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      preset_sel <= '0;
      set_volt   <= SET_RST;
      set_curr   <= SET_RST;
      set_pwr    <= SET_RST;
      first_q    <= '0;
      last_q     <= '0;
      loops_q    <= '0;
      stat_q     <= '0;
      mask_q     <= '0;
      pend_q     <= 1'b0;
      hrdata     <= 32'h0000_0000;
      irq        <= 1'b0;
    end else if (ce) begin
      preset_sel <= sel_d;
      set_volt   <= volt_d;
      set_curr   <= curr_d;
      set_pwr    <= pwr_d;
      first_q    <= first_d;
      last_q     <= last_d;
      loops_q    <= loops_d;
      stat_q     <= stat_d;
      mask_q     <= mask_d;
      pend_q     <= pend_d;
      hrdata     <= hrdata_d;
      irq        <= |(stat_d & mask_d);
    end
  end

  pss_preset_mem #(
    .WIDTH (3 * SET_W),
    .DEPTH (3)
  ) u_mem (
    .clk   (clk),
    .ce    (ce),
    .we    (mem_we),
    .waddr (mem_slot),
    .wdata ({set_pwr, set_curr, set_volt}),
    .re    (mem_re),
    .raddr (mem_slot),
    .rdata (mem_rdata)
  );

  pss_seq_engine u_seq (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .mode_we    (mode_we),
    .mode_val   (pss_mode_type'(hwdata[1:0])),
    .jump_we    (jump_we),
    .jump_val   (hwdata[STEP_W-1:0]),
    .first_step (first_q),
    .last_step  (last_q),
    .loop_count (loops_q),
    .step_tick  (step_tick),
    .mode_q     (seq_mode),
    .step_q     (cur_step),
    .rep_q      (cur_rep),
    .done_q     (seq_done)
  );

  recall_sel_a: assert property (@(posedge clk) disable iff (rst || !ce)
    wr && a_addr_q == ADR_RECALL && !running && hwdata <= 32'h3
    |=> preset_sel == $past(hwdata[1:0]))
    else $error("recall did not select slot");

  run_reject_a: assert property (@(posedge clk) disable iff (rst || !ce)
    wr && running && (a_addr_q == ADR_STORE || a_addr_q == ADR_RECALL)
    |-> !mem_we && !mem_re ##1 stat_q[EV_ERR])
    else $error("preset command accepted while running");

  store_slot_a: assert property (@(posedge clk) disable iff (rst || !ce)
    wr && a_addr_q == ADR_STORE && !running && hwdata >= 32'h1 && hwdata <= 32'h3
    |-> mem_we && mem_slot == hwdata[1:0] - 2'h1)
    else $error("store not written to slot");

  range_keep_a: assert property (@(posedge clk) disable iff (rst || !ce)
    wr && a_addr_q == ADR_LOOPS && hwdata > 32'h0000_03e7
    |=> loops_q == $past(loops_q) && stat_q[EV_ERR])
    else $error("out of range loop count taken");

  step_read_a: assert property (@(posedge clk) disable iff (rst || !ce)
    rd_req && haddr[7:0] == ADR_STEP
    |=> hrdata[STEP_W-1:0] == $past(cur_step) && hrdata[25:16] == $past(cur_rep))
    else $error("step query mismatch");

endmodule

// ---- bench/pss_host.sv ----
`timescale 1ns/10ps
module pss_host (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic [31:0]      rd_data,
  output logic             rd_tog,
  output logic             tmo
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    rd_data = 32'h00000000;
    rd_tog = 1'b0;
    tmo = 1'b0;
  end

  // Waits for hready at a rising edge, bounded
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1) tmo <= 1'b1;
  endtask

  // One single word transfer; entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, adr};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : ~hwdata;
    wait_ready();
    if (!wr) begin
      rd_data = hrdata;
      rd_tog = ~rd_tog;
    end
  endtask
endmodule

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); \
    end \
  end
module testbench;
  import pss_pkg::*;
  logic              clk;
  logic              rst;
  logic              ce;
  logic              step_tick;
  logic              hsel;
  logic              hwrite;
  logic              hreadyout;
  logic              hresp;
  logic              irq;
  logic              rd_tog;
  logic              tmo;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic [31:0]       rd_data;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [SLOT_W-1:0] preset_sel;
  logic [SET_W-1:0]  set_volt;
  logic [SET_W-1:0]  set_curr;
  logic [SET_W-1:0]  set_pwr;
  pss_mode_type      seq_mode;
  logic [STEP_W-1:0] cur_step;
  logic [LOOP_W-1:0] cur_rep;
  int                n_errors;
  int                samples_checked;
  logic [31:0]       seed;
  logic [39:0]       expq[$];

  pss_top u_pss_top (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .step_tick(step_tick), .set_volt(set_volt),
    .set_curr(set_curr), .set_pwr(set_pwr), .preset_sel(preset_sel), .seq_mode(seq_mode),
    .cur_step(cur_step), .cur_rep(cur_rep));

  pss_host u_pss_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .rd_data(rd_data),
    .rd_tog(rd_tog), .tmo(tmo));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] stepw(input int rep, input int step);
    return (32'(rep) << REP_LSB) | 32'(step);
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_pss_host.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back({a, e});
    u_pss_host.xfer(1'b0, a, 32'h00000000);
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      step_tick <= 1'b1;
      @(posedge clk);
      step_tick <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Takes the oldest expected read off the queue
  always @(rd_tog) begin
    logic [39:0] e;
    if ($time > 0) begin
      if (expq.size() == 0) begin
        n_errors++;
        $display("MISMATCH read unexpected expected none seen %h", rd_data);
      end else begin
        e = expq.pop_front();
        `CHK($sformatf("read %h", e[39:32]), e[31:0], rd_data)
      end
    end
  end

  always @(posedge tmo) begin
    n_errors++;
    finish_test();
  end

  initial begin
    #(100 * 60000);
    n_errors++;
    finish_test();
  end

  initial begin
    logic [7:0]  ta[4];
    logic [31:0] tm[4];
    int          tw[4];
    logic [7:0]  sa[3];
    logic [31:0] v[3][3];
    logic [31:0] g;
    logic [31:0] b;
    int          i;
    int          k;
    rst = 1'b1;
    ce = 1'b1;
    step_tick = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    seed = 32'hea327366;
    ta = '{ADR_FIRST, ADR_LAST, ADR_LOOPS, ADR_MODE};
    tm = '{32'(STEP_MAX), 32'(STEP_MAX), 32'(LOOP_MAX), 32'(MODE_MAX)};
    tw = '{STEP_W, STEP_W, LOOP_W, 2};
    sa = '{ADR_SET_V, ADR_SET_I, ADR_SET_P};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i <= 12; i++) rd(8'(i * 4), 32'h00000000);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      g = xs() & 32'h1 ? tm[i] : xs() % (tm[i] + 1);
      b = tm[i] + 1 + xs() % ((32'h1 << tw[i]) - tm[i] - 1);
      wr(ta[i], g);
      wr(ta[i], b);
      rd(ta[i], g);
      rd(ADR_STAT, 32'h1);
      wr(ADR_STAT, 32'h3);
    end
    wr(ADR_MODE, 32'h0);
    wr(ADR_STEP, 32'h5);
    rd(ADR_STAT, 32'h1);
    idle(2);
    `CHK("irq masked", 1'b0, irq)
    wr(ADR_STAT, 32'h3);
    $display("test range done");
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < 3; i++) begin
        v[k][i] = 32'(16'(xs()));
        wr(sa[i], v[k][i]);
      end
      wr(ADR_STORE, 32'(k + 1));
    end
    wr(ADR_STORE, 32'h0);
    rd(ADR_STAT, 32'h1);
    wr(ADR_STAT, 32'h3);
    for (k = 2; k >= 0; k--) begin
      wr(ADR_RECALL, 32'(k + 1));
      idle(3);
      `CHK("set_volt", 16'(v[k][0]), set_volt)
      `CHK("set_curr", 16'(v[k][1]), set_curr)
      `CHK("set_pwr", 16'(v[k][2]), set_pwr)
      `CHK("preset_sel", 2'(k + 1), preset_sel)
      rd(ADR_RECALL, 32'(k + 1));
    end
    wr(ADR_RECALL, 32'h0);
    rd(ADR_RECALL, 32'h0);
    $display("test preset done");
    wr(ADR_MASK, 32'h2);
    wr(ADR_FIRST, 32'h2);
    wr(ADR_LAST, 32'h4);
    wr(ADR_LOOPS, 32'h2);
    wr(ADR_MODE, 32'h1);
    idle(1);
    rd(ADR_MODE, 32'h1);
    rd(ADR_STEP, stepw(1, 2));
    wr(ADR_STEP, 32'h3);
    idle(1);
    rd(ADR_STEP, stepw(1, 3));
    wr(ADR_STEP, 32'h64);
    rd(ADR_STEP, stepw(1, 3));
    rd(ADR_STAT, 32'h1);
    wr(ADR_STAT, 32'h3);
    wr(ADR_MODE, 32'h2);
    idle(1);
    rd(ADR_MODE, 32'h2);
    wr(ADR_RECALL, 32'h1);
    wr(ADR_STORE, 32'h2);
    wr(ADR_STEP, 32'h4);
    rd(ADR_STAT, 32'h1);
    rd(ADR_RECALL, 32'h0);
    rd(ADR_STEP, stepw(1, 3));
    `CHK("hresp", 1'b0, hresp)
    `CHK("hreadyout", 1'b1, hreadyout)
    wr(ADR_STAT, 32'h3);
    tick(1);
    rd(ADR_STEP, stepw(1, 4));
    tick(1);
    rd(ADR_STEP, stepw(2, 2));
    tick(3);
    rd(ADR_MODE, 32'h0);
    rd(ADR_STAT, 32'h2);
    idle(1);
    `CHK("irq done", 1'b1, irq)
    wr(ADR_STAT, 32'h2);
    idle(2);
    `CHK("irq cleared", 1'b0, irq)
    $display("test sequence done");
    wr(ADR_FIRST, 32'h5);
    wr(ADR_LAST, 32'h6);
    wr(ADR_LOOPS, 32'h0);
    wr(ADR_MODE, 32'h2);
    tick(6);
    rd(ADR_STEP, stepw(4, 5));
    ce <= 1'b0;
    tick(2);
    ce <= 1'b1;
    `CHK("cur_step", 7'h05, cur_step)
    `CHK("cur_rep", 10'h004, cur_rep)
    `CHK("seq_mode", PSS_RUN, seq_mode)
    rd(ADR_MODE, 32'h2);
    wr(ADR_MODE, 32'h0);
    idle(1);
    rd(ADR_MODE, 32'h0);
    $display("test endless done");
    idle(2);
    finish_test();
  end
endmodule
